// ---- src/panel_line_clock_bias_ctrl.sv ----
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps

module panel_line_clock_bias_ctrl (
  // Clock, enable and reset
  input  wire logic                                 clk_sys,
  input  wire logic                                 rstn,
  input  wire logic                                 ce,
  // AXI4-Lite write address
  input  wire logic [panel_pkg::ADDR_W-1:0]         s_axi_awaddr,
  input  wire logic                                 s_axi_awvalid,
  output logic                                      s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                          s_axi_wdata,
  input  wire logic [3:0]                           s_axi_wstrb,
  input  wire logic                                 s_axi_wvalid,
  output logic                                      s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                                s_axi_bresp,
  output logic                                      s_axi_bvalid,
  input  wire logic                                 s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [panel_pkg::ADDR_W-1:0]         s_axi_araddr,
  input  wire logic                                 s_axi_arvalid,
  output logic                                      s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                               s_axi_rdata,
  output logic [1:0]                                s_axi_rresp,
  output logic                                      s_axi_rvalid,
  input  wire logic                                 s_axi_rready,
  // Panel timing from the display section
  input  wire logic                                 line_start,
  input  wire logic                                 frame_start,
  input  wire logic                                 vblank,
  input  wire logic                                 first_blank_line,
  input  wire logic                                 line_clock_src,
  input  wire logic                                 alt_line_clock_src,
  input  wire logic                                 line_clock_active_high,
  input  wire logic                                 alt_active_high,
  input  wire logic                                 shift_clock_src,
  // Bias toggle inputs
  input  wire logic                                 bias_src_clk,
  input  wire logic [panel_pkg::BIAS_CNT_W-1:0]     bias_cycle_count,
  input  wire logic                                 panel_enable_gate,
  // Panel outputs
  output logic                                      line_clock_out,
  output logic                                      alt_line_clock_out,
  output logic                                      bias_toggle_out,
  output logic                                      shift_clock_out,
  output logic [panel_pkg::SCLK_DLY_W-1:0]          shift_clock_dly_sel
);

  // ****************************************************************
  // Write and read bookkeeping
  // ****************************************************************
  logic                          awready_ff;
  logic                          wready_ff;
  logic                          bvalid_ff;
  logic [1:0]                    bresp_ff;
  logic                          aw_hold_ff;
  logic [panel_pkg::ADDR_W-1:0]  awaddr_ff;
  logic                          w_hold_ff;
  logic [31:0]                   wdata_ff;
  logic [3:0]                    wstrb_ff;
  logic                          arready_ff;
  logic                          rvalid_ff;
  logic [1:0]                    rresp_ff;
  logic [31:0]                   rdata_ff;

  // ****************************************************************
  // Register and shadow state
  // ****************************************************************
  logic [31:0]                   pin_ctrl_a_ff;
  logic [31:0]                   cfg_ff;
  logic [panel_pkg::SCLK_DLY_W-1:0] dly_ff;
  logic                          lc_out_ff;
  logic                          alt_out_ff;
  logic                          sclk_out_ff;
  logic                          bias_w;

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : merge_strb

  // ****************************************************************
  // Write channel
  // ****************************************************************
  wire logic aw_take = s_axi_awvalid & awready_ff;
  wire logic w_take  = s_axi_wvalid & wready_ff;
  wire logic aw_have = aw_hold_ff | aw_take;
  wire logic w_have  = w_hold_ff | w_take;
  wire logic do_write = aw_have & w_have & ~bvalid_ff;
  wire logic [panel_pkg::ADDR_W-1:0] wr_addr =
      aw_hold_ff ? awaddr_ff : s_axi_awaddr;
  wire logic [31:0] wr_data = w_hold_ff ? wdata_ff : s_axi_wdata;
  wire logic [3:0]  wr_strb = w_hold_ff ? wstrb_ff : s_axi_wstrb;
  wire logic wr_ctrl = do_write &
                       (wr_addr == panel_pkg::PIN_CTRL_A_OFFSET);
  wire logic wr_stat = wr_addr == panel_pkg::STATUS_OFFSET;
  wire logic nxt_aw_hold = aw_have & ~do_write;
  wire logic nxt_w_hold  = w_have & ~do_write;
  wire logic nxt_bvalid  = do_write | (bvalid_ff & ~s_axi_bready);
  wire logic nxt_awready = ~nxt_aw_hold & ~nxt_bvalid;
  wire logic nxt_wready  = ~nxt_w_hold & ~nxt_bvalid;
  wire logic [1:0] nxt_bresp =
      ~do_write ? bresp_ff :
      ((wr_ctrl | wr_stat) ? panel_pkg::RESP_OKAY
                           : panel_pkg::RESP_SLVERR);
  // Reserved bits are never stored, so they read back as zero.
  wire logic [31:0] nxt_pin_ctrl_a =
      wr_ctrl ? (merge_strb(pin_ctrl_a_ff, wr_data, wr_strb) &
                 panel_pkg::PIN_CTRL_A_MASK)
              : pin_ctrl_a_ff;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= panel_pkg::RESP_OKAY;
      aw_hold_ff <= 1'b0;
      awaddr_ff  <= '0;
      w_hold_ff  <= 1'b0;
      wdata_ff   <= '0;
      wstrb_ff   <= '0;
    end else if (ce) begin
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff  <= nxt_w_hold;
      if (aw_take) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  wire logic ar_take = s_axi_arvalid & arready_ff;
  wire logic rd_ctrl = s_axi_araddr == panel_pkg::PIN_CTRL_A_OFFSET;
  wire logic rd_stat = s_axi_araddr == panel_pkg::STATUS_OFFSET;
  wire logic first_on = first_blank_line &
                        cfg_ff[panel_pkg::FIRST_LINE_BIT];
  wire logic lc_pass  = ~vblank | cfg_ff[panel_pkg::LC_VBLANK_BIT] |
                        first_on;
  wire logic alt_pass = ~vblank | cfg_ff[panel_pkg::ALT_VBLANK_BIT] |
                        first_on;
  wire logic [31:0] status_w =
      (32'h1 << panel_pkg::ST_BIAS_BIT) & {32{bias_toggle_out}} |
      (32'h1 << panel_pkg::ST_VBLANK_BIT) & {32{vblank}} |
      (32'h1 << panel_pkg::ST_LC_RUN_BIT) & {32{lc_pass}} |
      (32'h1 << panel_pkg::ST_ALT_RUN_BIT) & {32{alt_pass}};
  wire logic [31:0] rd_data =
      rd_ctrl ? pin_ctrl_a_ff : (rd_stat ? status_w : 32'h0000_0000);
  wire logic nxt_rvalid  = ar_take | (rvalid_ff & ~s_axi_rready);
  wire logic nxt_arready = ~nxt_rvalid;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= panel_pkg::RESP_OKAY;
      rdata_ff   <= '0;
    end else if (ce) begin
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      if (ar_take) begin
        rdata_ff <= rd_data;
        rresp_ff <= (rd_ctrl | rd_stat) ? panel_pkg::RESP_OKAY
                                        : panel_pkg::RESP_SLVERR;
      end
    end
  end

  // ****************************************************************
  // Register and boundary shadows
  // ****************************************************************
  // The working copy follows the register at each frame start, so a
  // write never cuts a frame in half; the delay code follows at each line start.
  wire logic [31:0] nxt_cfg = frame_start ? pin_ctrl_a_ff : cfg_ff;
  wire logic [panel_pkg::SCLK_DLY_W-1:0] nxt_dly =
      line_start ? pin_ctrl_a_ff[panel_pkg::SCLK_DLY_LSB +:
                                 panel_pkg::SCLK_DLY_W]
                 : dly_ff;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_ctrl_a_ff <= panel_pkg::PIN_CTRL_A_RESET;
      cfg_ff        <= panel_pkg::PIN_CTRL_A_RESET;
      dly_ff        <= '0;
    end else if (ce) begin
      pin_ctrl_a_ff <= nxt_pin_ctrl_a;
      cfg_ff        <= nxt_cfg;
      dly_ff        <= nxt_dly;
    end
  end

  // ****************************************************************
  // Line clock gating in vertical blank
  // ****************************************************************
  wire logic nxt_lc  = lc_pass ? line_clock_src
                               : ~line_clock_active_high;
  wire logic nxt_alt = alt_pass ? alt_line_clock_src
                                : ~alt_active_high;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lc_out_ff   <= 1'b0;
      alt_out_ff  <= 1'b0;
      sclk_out_ff <= 1'b0;
    end else if (ce) begin
      lc_out_ff   <= nxt_lc;
      alt_out_ff  <= nxt_alt;
      sclk_out_ff <= shift_clock_src;
    end
  end

  // ****************************************************************
  // Bias toggle
  // ****************************************************************
  bias_toggle_gen u_bias (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .ce          (ce),
    .edge_rise   (cfg_ff[panel_pkg::BIAS_EDGE_BIT]),
    .frame_inv   (cfg_ff[panel_pkg::BIAS_FRAME_INV_BIT]),
    .gate_mode   (cfg_ff[panel_pkg::BIAS_FREQ_BIT]),
    .sync_rst    (cfg_ff[panel_pkg::BIAS_SYNC_RST_BIT]),
    .cycle_count (bias_cycle_count),
    .src_clk     (bias_src_clk),
    .frame_start (frame_start),
    .enable_gate (panel_enable_gate),
    .bias_out    (bias_w)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready       = awready_ff;
  assign s_axi_wready        = wready_ff;
  assign s_axi_bvalid        = bvalid_ff;
  assign s_axi_bresp         = bresp_ff;
  assign s_axi_arready       = arready_ff;
  assign s_axi_rvalid        = rvalid_ff;
  assign s_axi_rdata         = rdata_ff;
  assign s_axi_rresp         = rresp_ff;
  assign line_clock_out      = lc_out_ff;
  assign alt_line_clock_out  = alt_out_ff;
  assign bias_toggle_out     = bias_w;
  assign shift_clock_out     = sclk_out_ff;
  assign shift_clock_dly_sel = dly_ff;

endmodule : panel_line_clock_bias_ctrl

// ---- src/panel_pkg.sv ----
package panel_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] PIN_CTRL_A_OFFSET = 12'h604;
  localparam logic [11:0] STATUS_OFFSET     = 12'h700;
  localparam int          ADDR_W            = 12;

  // ****************************************************************
  // Pin control field positions
  // ****************************************************************
  localparam int LC_VBLANK_BIT      = 18;
  localparam int ALT_VBLANK_BIT     = 19;
  localparam int BIAS_EDGE_BIT      = 20;
  localparam int BIAS_FRAME_INV_BIT = 21;
  localparam int BIAS_FREQ_BIT      = 22;
  localparam int BIAS_SYNC_RST_BIT  = 23;
  localparam int SCLK_DLY_LSB       = 24;
  localparam int SCLK_DLY_W         = 3;
  localparam int FIRST_LINE_BIT     = 27;

  // ****************************************************************
  // Reset values and masks
  // ****************************************************************
  localparam logic [31:0] PIN_CTRL_A_RESET = 32'h0000_0000;
  // Bits 31:28 are reserved and always read as zero.
  localparam logic [31:0] PIN_CTRL_A_MASK  = 32'h0fff_ffff;

  // ****************************************************************
  // Status field positions
  // ****************************************************************
  localparam int ST_BIAS_BIT    = 0;
  localparam int ST_VBLANK_BIT  = 1;
  localparam int ST_LC_RUN_BIT  = 2;
  localparam int ST_ALT_RUN_BIT = 3;

  // ****************************************************************
  // Bus responses and widths
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int         BIAS_CNT_W  = 7;

  // ****************************************************************
  // Timing
  // ****************************************************************
  // Nominal span of the shift clock pad delay, in ns, code 0 to 7.
  localparam int SCLK_DLY_SPAN_NS = 7;

endpackage : panel_pkg

// ---- src/bias_toggle_gen.sv ----
`timescale 1ns/1ps

module bias_toggle_gen (
  // Clock and reset
  input  wire logic                               clk_sys,
  input  wire logic                               rstn,
  input  wire logic                               ce,
  // Control
  input  wire logic                               edge_rise,
  input  wire logic                               frame_inv,
  input  wire logic                               gate_mode,
  input  wire logic                               sync_rst,
  input  wire logic [panel_pkg::BIAS_CNT_W-1:0]   cycle_count,
  // Timing
  input  wire logic                               src_clk,
  input  wire logic                               frame_start,
  input  wire logic                               enable_gate,
  // Output
  output logic                                    bias_out
);

  logic                             src_prev_ff;
  logic                             pol_ff;
  logic                             phase_ff;
  logic [panel_pkg::BIAS_CNT_W-1:0] cnt_ff;
  logic                             bias_ff;

  // ****************************************************************
  // Active edge and toggle decision
  // ****************************************************************
  wire logic act_edge = edge_rise ? (src_clk & ~src_prev_ff)
                                  : (~src_clk & src_prev_ff);
  wire logic cnt_done = (cnt_ff >= cycle_count);
  // Gate mode changes state only while the enable gate is low.
  wire logic do_toggle = act_edge &
                         (gate_mode ? ~enable_gate : cnt_done);
  wire logic [panel_pkg::BIAS_CNT_W-1:0] nxt_cnt =
      (frame_start & sync_rst) ? '0 :
      (act_edge & ~gate_mode) ?
        (cnt_done ? '0 : cnt_ff + 7'h01) : cnt_ff;
  wire logic nxt_pol =
      (frame_start & sync_rst) ? 1'b0 :
      (do_toggle ? ~pol_ff : pol_ff);
  wire logic nxt_phase = (frame_start & frame_inv) ? ~phase_ff
                                                   : phase_ff;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      src_prev_ff <= 1'b0;
      pol_ff      <= 1'b0;
      phase_ff    <= 1'b0;
      cnt_ff      <= '0;
      bias_ff     <= 1'b0;
    end else if (ce) begin
      src_prev_ff <= src_clk;
      pol_ff      <= nxt_pol;
      phase_ff    <= nxt_phase;
      cnt_ff      <= nxt_cnt;
      bias_ff     <= nxt_pol ^ nxt_phase;
    end
  end

  assign bias_out = bias_ff;

endmodule : bias_toggle_gen

// ---- bench/panel_timing_model.sv ----
`timescale 1ns/1ps

module panel_timing_model (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // Panel set-up
  input  wire logic line_clock_active_high,
  input  wire logic alt_active_high,
  input  wire logic bias_run,
  // Timing towards the controller
  output logic      line_start,
  output logic      frame_start,
  output logic      vblank,
  output logic      first_blank_line,
  output logic      line_clock_src,
  output logic      alt_line_clock_src,
  output logic      shift_clock_src,
  output logic      bias_src_clk
);
  // ********
  // Raster of 16-cycle lines, 5 shown and 3 blank.
  // ********
  logic [3:0] pix_ff;
  logic [2:0] line_ff;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pix_ff  <= 4'h0;
      line_ff <= 3'h0;
    end else begin
      pix_ff  <= pix_ff + 4'h1;
      line_ff <= line_ff + 3'(pix_ff == 4'hf);
    end
  end

  assign line_start         = pix_ff == 4'h0;
  assign frame_start        = line_start && line_ff == 3'h0;
  assign vblank             = line_ff >= 3'h5;
  assign first_blank_line   = line_ff == 3'h5;
  assign line_clock_src     = (pix_ff[3:1] == 3'h6) ^ ~line_clock_active_high;
  assign alt_line_clock_src = (pix_ff[3:1] == 3'h2) ^ ~alt_active_high;
  assign shift_clock_src    = pix_ff[0];
  // The bias source follows the line rate and stands low when stopped.
  assign bias_src_clk       = bias_run & pix_ff[3];
endmodule : panel_timing_model

// ---- bench/line_bias_checker.sv ----
`timescale 1ns/1ps

module line_bias_checker (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        ce,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  // Panel timing
  input wire logic        line_start,
  input wire logic        frame_start,
  input wire logic        vblank,
  input wire logic        first_blank_line,
  input wire logic        line_clock_src,
  input wire logic        alt_line_clock_src,
  input wire logic        line_clock_active_high,
  input wire logic        shift_clock_src,
  input wire logic        bias_src_clk,
  // Panel outputs
  input wire logic        line_clock_out,
  input wire logic        alt_line_clock_out,
  input wire logic        bias_toggle_out,
  input wire logic        shift_clock_out,
  input wire logic [2:0]  shift_clock_dly_sel
);
  // ********
  // Recent causes for a bias change.
  // ********
  logic [4:0] cause_ff;
  logic       src_ff;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cause_ff <= 5'h00;
      src_ff   <= 1'b0;
    end else begin
      cause_ff <= {cause_ff[3:0], frame_start | (bias_src_clk ^ src_ff)};
      src_ff   <= bias_src_clk;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_lc_run;
    ce && !vblank ##1 ce;
  endsequence
  sequence s_lc_hold;
    ce && vblank && !first_blank_line ##1 ce;
  endsequence
  sequence s_wr_taken;
    ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  AST_LC_PASS: assert property (
    s_lc_run |-> line_clock_out == $past(line_clock_src))
    else $error("line clock not passed outside blank");
  AST_LC_IDLE: assert property (s_lc_hold |->
    line_clock_out == $past(line_clock_src) ||
    line_clock_out == !$past(line_clock_active_high))
    else $error("stopped line clock not at inactive level");
  AST_ALT_PASS: assert property (
    s_lc_run |-> alt_line_clock_out == $past(alt_line_clock_src))
    else $error("alternate line clock not passed");
  AST_SCLK_DELAY: assert property (
    ce ##1 ce |-> shift_clock_out == $past(shift_clock_src))
    else $error("shift clock not one cycle behind");
  AST_DLY_ON_LINE: assert property (
    $changed(shift_clock_dly_sel) |-> $past(line_start))
    else $error("delay code changed off a line start");
  AST_BIAS_CAUSE: assert property (
    $changed(bias_toggle_out) |-> |cause_ff)
    else $error("bias changed without source edge or frame");
  AST_WR_RESP: assert property (
    s_wr_taken |=> s_axi_bvalid)
    else $error("write response late");
  AST_RD_SLVERR: assert property (
    ce && s_axi_arvalid && s_axi_arready &&
    s_axi_araddr != panel_pkg::PIN_CTRL_A_OFFSET &&
    s_axi_araddr != panel_pkg::STATUS_OFFSET |=> s_axi_rvalid &&
    s_axi_rresp == panel_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule : line_bias_checker

bind panel_line_clock_bias_ctrl line_bias_checker i_chk (
  .clk_sys, .rstn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .line_start, .frame_start, .vblank, .first_blank_line, .line_clock_src,
  .alt_line_clock_src, .line_clock_active_high, .shift_clock_src,
  .bias_src_clk, .line_clock_out, .alt_line_clock_out, .bias_toggle_out,
  .shift_clock_out, .shift_clock_dly_sel
);

// ---- bench/tb.sv ----
`timescale 1ns/1ps

module tb;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        ce = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, bias_run = 1'b1;
  logic        line_clock_active_high = 1'b1, alt_active_high = 1'b1;
  logic        panel_enable_gate = 1'b0;
  logic [6:0]  bias_cycle_count = 7'h00;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, reg_m = 32'h0, wcfg = 32'h0;
  logic        line_start, frame_start, vblank, first_blank_line;
  logic        line_clock_src, alt_line_clock_src;
  logic        shift_clock_src, bias_src_clk;
  logic        line_clock_out, alt_line_clock_out;
  logic        bias_toggle_out, shift_clock_out;
  logic [2:0]  shift_clock_dly_sel;
  logic        e_lc, e_alc, e_sc, b_q, s_q, mon = 1'b0;
  int          errors = 0, n_compared = 0, nchg = 0, age = 0;

  always #12.5 clk_sys = ~clk_sys;

  panel_line_clock_bias_ctrl i_dut (
    .clk_sys, .rstn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .line_start, .frame_start, .vblank,
    .first_blank_line, .line_clock_src, .alt_line_clock_src,
    .line_clock_active_high, .alt_active_high, .shift_clock_src,
    .bias_src_clk, .bias_cycle_count, .panel_enable_gate,
    .line_clock_out, .alt_line_clock_out, .bias_toggle_out,
    .shift_clock_out, .shift_clock_dly_sel
  );

  panel_timing_model i_panel (
    .clk_sys, .rstn, .line_clock_active_high, .alt_active_high, .bias_run,
    .line_start, .frame_start, .vblank, .first_blank_line,
    .line_clock_src, .alt_line_clock_src, .shift_clock_src, .bias_src_clk
  );

  // ********
  // Reference of the panel outputs.
  // ********
  function automatic logic gated(input logic run, src, act_high);
    return run ? src : ~act_high;
  endfunction : gated

  function automatic int toggles(input int cnt);
    return 8 / (cnt + 1);
  endfunction : toggles

  always @(posedge clk_sys) begin
    if (frame_start) wcfg <= reg_m;
    e_lc  <= gated(~vblank | wcfg[18] | first_blank_line & wcfg[27],
                   line_clock_src, line_clock_active_high);
    e_alc <= gated(~vblank | wcfg[19] | first_blank_line & wcfg[27],
                   alt_line_clock_src, alt_active_high);
    e_sc  <= shift_clock_src;
    b_q   <= bias_toggle_out;
    s_q   <= bias_src_clk;
    age   <= (wcfg[20] ? bias_src_clk & ~s_q : ~bias_src_clk & s_q) ?
             0 : age + 1;
    if (bias_toggle_out !== b_q) nchg <= nchg + 1;
    if (mon && bias_run && bias_toggle_out !== b_q) check(age <= 4, 1);
  end

  always @(negedge clk_sys) begin
    if (mon) begin
      check(line_clock_out, e_lc);
      check(alt_line_clock_out, e_alc);
      check(shift_clock_out, e_sc);
    end
  end

  // ********
  // Checking, bus and closing tasks.
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  task automatic hang;
    errors++;
    stop_test();
  endtask : hang

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 50) hang();
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50) hang();
  endtask : rd

  // Writes the control word and waits until a frame start has loaded it.
  task automatic cfg(input logic [31:0] v);
    logic [1:0] r;
    int n;
    wr(panel_pkg::PIN_CTRL_A_OFFSET, v, r);
    mon   <= 1'b0;
    reg_m <= v;
    check(r, panel_pkg::RESP_OKAY);
    for (n = 0; n < 300; n++) begin
      @(posedge clk_sys);
      if (frame_start) break;
    end
    @(posedge clk_sys);
    mon <= 1'b1;
    if (n == 300) hang();
  endtask : cfg

  task automatic bias_win(input logic [31:0] v, input int e);
    int c0;
    cfg(v);
    @(posedge clk_sys);
    c0 = nchg;
    repeat (128) @(posedge clk_sys);
    check(nchg - c0, e);
  endtask : bias_win

  initial begin
    repeat (50000) @(posedge clk_sys);
    hang();
  end

  initial begin
    logic [31:0] d, v;
    logic [1:0]  r;
    logic [2:0]  k;
    int          i;
    void'($urandom(32'h82e2662d));
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(panel_pkg::PIN_CTRL_A_OFFSET, d, r);
    check(d, panel_pkg::PIN_CTRL_A_RESET);
    for (i = 0; i < 4; i++) begin
      v = (i == 0) ? 32'h0fff_ffff : $urandom & 32'h0fff_ffff;
      wr(panel_pkg::PIN_CTRL_A_OFFSET, v, r);
      rd(panel_pkg::PIN_CTRL_A_OFFSET, d, r);
      check(d, v);
    end
    wr(12'h10c, 32'h0000_0001, r);
    check(r, panel_pkg::RESP_SLVERR);
    rd(12'h10c, d, r);
    check(r, panel_pkg::RESP_SLVERR);
    check(d, 32'h0);
    rd(panel_pkg::STATUS_OFFSET, d, r);
    check(r, panel_pkg::RESP_OKAY);
    rd(panel_pkg::PIN_CTRL_A_OFFSET, d, r);
    check(d, v);
    for (i = 0; i < 8; i++) begin
      line_clock_active_high <= 1'($urandom);
      alt_active_high        <= 1'($urandom);
      k = 3'(i);
      cfg({4'h0, k[2], k, 4'h0, k[1:0], 18'h0});
      repeat (256) @(posedge clk_sys);
      check(shift_clock_dly_sel, k);
    end
    for (i = 0; i < 4; i++) begin
      bias_cycle_count <= 7'((1 << i) - 1);
      bias_win(32'h0, toggles((1 << i) - 1));
    end
    bias_cycle_count  <= 7'h00;
    panel_enable_gate <= 1'b1;
    bias_win(32'h0040_0000, 0);
    panel_enable_gate <= 1'b0;
    bias_win(32'h0040_0000, 8);
    bias_win(32'h0010_0000, 8);
    bias_run <= 1'b0;
    cfg(32'h0080_0000);
    repeat (128) @(posedge clk_sys);
    check(bias_toggle_out, 1'b0);
    bias_win(32'h0080_0000, 0);
    bias_win(32'h0020_0000, 1);
    stop_test();
  end
endmodule : tb
